// ---- design/sync_serial_master_tx.sv ----
// synchronous master transmit path of a serial port with apb register access
// Operation
// - divisor 51 at 8 MHz or 25 at 4 MHz yields 9615 baud, high speed async
// - as master the port generates baud timing and supplies the link clock
// - one data line and one clock line; never send and receive together
// - characters carry data bits only, no start or stop bit
// - sync mode select bit puts the port in synchronous operation
// - clock source select bit makes the port master, driving the clock
// - both receive enables clear means transmit mode, otherwise receive
// - serial port enable bit enables the port; clear keeps it inactive
// - master drives link clock on the transmit clock pin
// - clock pin driver enabled automatically for sync master transmit or receive
// - data changes on leading clock edge, sampled on trailing edge
// - exactly one clock cycle per data bit, no extra clocks
// - sync master transmit data leaves on the receive data pin
// - data and clock pin drivers enabled automatically in sync master transmit
// - new character waits in holding buffer until previous last bit is out
// - empty shift register takes holding buffer contents at once
// - shifting starts right after transfer into the shift register
// - each bit changes on a leading edge, stable until the next one
// - shift register is not software visible
// - transmission needs transmit enable bit besides sync master setup
// - nine bit select sends nine bits; ninth bit loaded before buffer write
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sync_tx_cfg.svh"

module sync_serial_master_tx (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic transmit_clock_pin_in,
  output logic transmit_clock_pin_out,
  output logic transmit_clock_pin_oe,
  input wire logic receive_data_pin_in,
  output logic receive_data_pin_out,
  output logic receive_data_pin_oe,
  output logic baud_tick
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_pipe;
  logic rst_n;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  assign rst_n = rst_pipe[1];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sync_tx_pkg::tx_regs_s s;
  sync_tx_pkg::tx_regs_s next_s;

  logic port_on;
  logic master_cfg;
  logic tx_active;
  logic nine;
  logic [5:0] pre_top;
  logic wr_en;
  logic [31:0] rd_mux;
  logic rd_ok;

  always_comb begin
    port_on = s.rsc[`RSC_PORT_ENABLE];
    master_cfg = port_on & s.tsc[`TSC_SYNC_MODE] & s.tsc[`TSC_CLOCK_SOURCE];
    tx_active = master_cfg & s.tsc[`TSC_TX_ENABLE]
      & ~s.rsc[`RSC_SINGLE_RX] & ~s.rsc[`RSC_CONT_RX];
    nine = s.tsc[`TSC_NINE_BIT];
    if (s.tsc[`TSC_SYNC_MODE]) begin
      pre_top = `PRE_SYNC;
    end else if (s.tsc[`TSC_HIGH_BAUD]) begin
      pre_top = `PRE_ASYNC_HIGH;
    end else begin
      pre_top = `PRE_ASYNC_LOW;
    end
    wr_en = psel & penable & s.pready & pwrite;
    rd_ok = 1'b1;
    rd_mux = 32'h0;
    case (paddr)
      `OFS_TX_CTRL: rd_mux = {24'h0, (s.tsc & `TSC_WMASK)
        | {6'h0, s.state == sync_tx_pkg::idle, 1'b0}};
      `OFS_RX_CTRL: rd_mux = {24'h0, s.rsc & `RSC_WMASK};
      `OFS_BAUD: rd_mux = {24'h0, s.baud};
      `OFS_TX_DATA: rd_mux = 32'h0;
      `OFS_STATUS: rd_mux = {29'h0, s.dt_sync[1], s.ck_sync[1], s.hold_full};
      default: rd_ok = 1'b0;
    endcase
  end

  always_comb begin
    next_s = s;
    next_s.baud_tick = 1'b0;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    next_s.ck_sync = {s.ck_sync[0], transmit_clock_pin_in};
    next_s.dt_sync = {s.dt_sync[0], receive_data_pin_in};

    // ----------------------------------------------------------------
    // apb slave
    // ----------------------------------------------------------------
    if (psel && !penable) begin
      next_s.pready = 1'b1;
      next_s.pslverr = ~rd_ok;
      next_s.prdata = pwrite ? 32'h0 : rd_mux;
    end

    // ----------------------------------------------------------------
    // baud generator
    // ----------------------------------------------------------------
    if (!port_on) begin
      next_s.pre = 6'h0;
      next_s.div = s.baud;
    end else if (s.pre == pre_top - 6'h1) begin
      next_s.pre = 6'h0;
      if (s.div == 8'h0) begin
        next_s.div = s.baud;
        next_s.baud_tick = 1'b1;
      end else begin
        next_s.div = s.div - 8'h1;
      end
    end else begin
      next_s.pre = s.pre + 6'h1;
    end

    // ----------------------------------------------------------------
    // transmitter
    // ----------------------------------------------------------------
    case (s.state)
      sync_tx_pkg::idle: begin
        next_s.ck_out = 1'b0;
        if (tx_active && s.hold_full) begin
          next_s.shifter = s.hold_data;
          next_s.hold_full = 1'b0;
          next_s.bits_left = nine ? 4'h9 : 4'h8;
          next_s.state = sync_tx_pkg::shift;
        end
      end
      sync_tx_pkg::shift: begin
        if (!tx_active) begin
          next_s.state = sync_tx_pkg::idle;
          next_s.ck_out = 1'b0;
          next_s.shifter = 9'h0;
        end else if (s.baud_tick) begin
          if (s.ck_out) begin
            next_s.ck_out = 1'b0;
          end else if (s.bits_left == 4'h0) begin
            next_s.state = sync_tx_pkg::idle;
          end else begin
            next_s.ck_out = 1'b1;
            next_s.dt_out = s.shifter[0];
            next_s.shifter = {1'b0, s.shifter[8:1]};
            next_s.bits_left = s.bits_left - 4'h1;
          end
        end
      end
      default: next_s.state = sync_tx_pkg::idle;
    endcase

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    if (wr_en) begin
      case (paddr)
        `OFS_TX_CTRL: next_s.tsc = pwdata[7:0] & `TSC_WMASK;
        `OFS_RX_CTRL: next_s.rsc = pwdata[7:0] & `RSC_WMASK;
        `OFS_BAUD: next_s.baud = pwdata[7:0];
        `OFS_TX_DATA: begin
          next_s.hold_data = {s.tsc[`TSC_NINTH_BIT], pwdata[7:0]};
          next_s.hold_full = 1'b1;
        end
        default: next_s.hold_full = next_s.hold_full;
      endcase
    end
    if (!port_on) begin
      next_s.hold_full = 1'b0;
    end

    next_s.ck_oe = next_s.rsc[`RSC_PORT_ENABLE] & next_s.tsc[`TSC_SYNC_MODE]
      & next_s.tsc[`TSC_CLOCK_SOURCE];
    next_s.dt_oe = next_s.ck_oe & next_s.tsc[`TSC_TX_ENABLE]
      & ~next_s.rsc[`RSC_SINGLE_RX] & ~next_s.rsc[`RSC_CONT_RX];
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.tsc <= `TSC_RESET;
      s.rsc <= `RSC_RESET;
      s.baud <= `BAUD_RESET;
      s.state <= sync_tx_pkg::idle;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign transmit_clock_pin_out = s.ck_out;
  assign transmit_clock_pin_oe = s.ck_oe;
  assign receive_data_pin_out = s.dt_out;
  assign receive_data_pin_oe = s.dt_oe;
  assign baud_tick = s.baud_tick;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [3:0] rise_count;
  logic [3:0] char_len;
  logic [14:0] tick_gap;
  logic [14:0] gap_want;
  logic [1:0] gap_seen;
  logic loading;

  assign loading = s.state == sync_tx_pkg::idle && next_s.state == sync_tx_pkg::shift;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rise_count <= 4'h0;
    end else if (loading) begin
      rise_count <= 4'h0;
    end else if (!s.ck_out && next_s.ck_out) begin
      rise_count <= rise_count + 4'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      char_len <= 4'h8;
    end else if (loading) begin
      char_len <= nine ? 4'h9 : 4'h8;
    end
  end

  assign gap_want = 15'(pre_top) * (15'(s.baud) + 15'h1);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick_gap <= 15'h0;
      gap_seen <= 2'h0;
    end else begin
      if (s.baud_tick) begin
        tick_gap <= 15'h1;
      end else if (tick_gap != 15'h7FFF) begin
        tick_gap <= tick_gap + 15'h1;
      end
      if (!port_on || (wr_en && paddr != `OFS_TX_DATA)) begin
        gap_seen <= 2'h0;
      end else if (s.baud_tick && gap_seen != 2'h2) begin
        gap_seen <= gap_seen + 2'h1;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  clock_count_limit_a: assert property (
    (s.state == sync_tx_pkg::shift) |-> (rise_count <= char_len))
    else $error("more clock pulses than data bits");

  char_clock_total_a: assert property (
    (s.state == sync_tx_pkg::shift && next_s.state == sync_tx_pkg::idle && tx_active)
    |-> rise_count == char_len)
    else $error("character ended with wrong clock count");

  data_on_lead_a: assert property (
    (s.state == sync_tx_pkg::shift && $changed(s.dt_out)) |-> $rose(s.ck_out))
    else $error("data changed away from leading edge");

  data_trail_stable_a: assert property (
    $fell(s.ck_out) |-> $stable(s.dt_out))
    else $error("data moved on trailing edge");

  holding_load_a: assert property (
    (s.state == sync_tx_pkg::idle && s.hold_full && tx_active && !wr_en)
    |=> (s.state == sync_tx_pkg::shift && !s.hold_full))
    else $error("holding buffer not moved to empty shifter");

  holding_wait_a: assert property (
    (s.state == sync_tx_pkg::shift && s.hold_full && tx_active && s.bits_left != 4'h0)
    |=> s.hold_full)
    else $error("holding buffer drained while shifting");

  port_off_quiet_a: assert property (
    !port_on |=> (!s.ck_oe && !s.dt_oe))
    else $error("drivers on with port disabled");

  receive_no_drive_a: assert property (
    (s.rsc[`RSC_SINGLE_RX] || s.rsc[`RSC_CONT_RX]) |-> !s.dt_oe)
    else $error("data driver on in receive mode");

  master_clock_oe_a: assert property (
    s.ck_oe == master_cfg)
    else $error("clock driver does not follow master setup");

  tx_disable_stop_a: assert property (
    (s.state == sync_tx_pkg::shift && !s.tsc[`TSC_TX_ENABLE]) |=> s.state == sync_tx_pkg::idle)
    else $error("shifting continued without transmit enable");

  apb_ready_a: assert property (
    (psel && !penable) |=> s.pready)
    else $error("access phase not ready");

  divider_period_a: assert property (
    (s.baud_tick && gap_seen == 2'h2) |-> tick_gap == gap_want)
    else $error("divider tick spacing wrong");

  shift_start_a: assert property (
    loading |=> (s.state == sync_tx_pkg::shift && s.bits_left == char_len))
    else $error("shifting did not start after load");

  idle_clock_low_a: assert property (
    (s.state == sync_tx_pkg::idle) |-> !s.ck_out)
    else $error("link clock high between characters");

  clock_from_divider_a: assert property (
    (s.state == sync_tx_pkg::shift && $changed(s.ck_out)) |-> $past(s.baud_tick))
    else $error("link clock moved without divider tick");

  no_stop_bit_a: assert property (
    (s.state == sync_tx_pkg::shift && s.bits_left == 4'h0 && !s.ck_out) |=> !s.ck_out)
    else $error("extra clock after last data bit");

  shifter_hidden_a: assert property (
    (psel && !penable && !pwrite && paddr == `OFS_TX_DATA) |=> s.prdata == 32'h0)
    else $error("transmit data register readable");

  port_off_flush_a: assert property (
    !port_on |=> !s.hold_full)
    else $error("holding buffer kept with port disabled");

  holding_capture_a: assert property (
    (wr_en && port_on && paddr == `OFS_TX_DATA)
    |=> (s.hold_full && s.hold_data == {$past(s.tsc[`TSC_NINTH_BIT]), $past(pwdata[7:0])}))
    else $error("holding buffer did not take the character");

  bit_order_a: assert property (
    $rose(s.ck_out) |-> s.dt_out == $past(s.shifter[0]))
    else $error("data bit not taken lsb first");

  bit_budget_a: assert property (
    $rose(s.ck_out) |-> $past(s.bits_left) != 4'h0)
    else $error("clock pulse without a data bit left");

  receive_abort_a: assert property (
    (s.state == sync_tx_pkg::shift && (s.rsc[`RSC_SINGLE_RX] || s.rsc[`RSC_CONT_RX]))
    |=> s.state == sync_tx_pkg::idle)
    else $error("shifting went on in receive mode");

  nine_bit_char_c: cover property (loading && nine);
  back_to_back_c: cover property (s.hold_full && s.state == sync_tx_pkg::shift ##1
    s.state == sync_tx_pkg::shift [*2]);
  abort_c: cover property (s.state == sync_tx_pkg::shift && !tx_active);
  unmapped_c: cover property (s.pslverr);
  byte_done_c: cover property (s.state == sync_tx_pkg::shift && next_s.state == sync_tx_pkg::idle && tx_active);

endmodule : sync_serial_master_tx
`default_nettype wire

// ---- inc/sync_tx_cfg.svh ----
// offsets, field positions, reset values and divider constants for the serial transmitter
`ifndef SYNC_TX_CFG_SVH
`define SYNC_TX_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_TX_CTRL 8'h00
`define OFS_RX_CTRL 8'h04
`define OFS_BAUD 8'h08
`define OFS_TX_DATA 8'h0C
`define OFS_STATUS 8'h10

// ----------------------------------------------------------------
// transmit_status_control fields
// ----------------------------------------------------------------
`define TSC_CLOCK_SOURCE 7
`define TSC_NINE_BIT 6
`define TSC_TX_ENABLE 5
`define TSC_SYNC_MODE 4
`define TSC_HIGH_BAUD 2
`define TSC_SHIFT_EMPTY 1
`define TSC_NINTH_BIT 0
`define TSC_WMASK 8'hF5
`define TSC_RESET 8'h00

// ----------------------------------------------------------------
// receive_status_control fields
// ----------------------------------------------------------------
`define RSC_PORT_ENABLE 7
`define RSC_SINGLE_RX 5
`define RSC_CONT_RX 4
`define RSC_WMASK 8'hB0
`define RSC_RESET 8'h00
`define BAUD_RESET 8'h00

// ----------------------------------------------------------------
// divider prescale per mode, in system clocks
// ----------------------------------------------------------------
`define PRE_SYNC 6'h02
`define PRE_ASYNC_HIGH 6'h10
`define PRE_ASYNC_LOW 6'h40

`endif

// ---- inc/sync_tx_pkg.sv ----
// types shared by the synchronous serial transmitter
package sync_tx_pkg;

  typedef enum logic [0:0] {
    idle,
    shift
  } tx_state_e;

  typedef struct packed {
    logic [7:0] tsc;
    logic [7:0] rsc;
    logic [7:0] baud;
    logic [8:0] hold_data;
    logic hold_full;
    logic [8:0] shifter;
    logic [3:0] bits_left;
    tx_state_e state;
    logic [5:0] pre;
    logic [7:0] div;
    logic baud_tick;
    logic ck_out;
    logic ck_oe;
    logic dt_out;
    logic dt_oe;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [1:0] ck_sync;
    logic [1:0] dt_sync;
  } tx_regs_s;

endpackage : sync_tx_pkg

// ---- tb/slave_rx_model.sv ----
// behavioural slave receiver on the synchronous link
`timescale 1ns/1ps
`default_nettype none

module slave_rx_model (
  input wire logic ck,
  input wire logic dt,
  input wire logic clr,
  output logic [17:0] data,
  output int nbits,
  output int nrise,
  output realtime per
);
  realtime last = 0;
  // ------------------------------------------------------------
  // capture, listen only, never drives the data line
  // ------------------------------------------------------------
  always @(posedge clr) begin
    data = '0;
    nbits = 0;
    nrise = 0;
  end
  always @(posedge ck) begin
    per = $realtime - last;
    last = $realtime;
    nrise = nrise + 1;
  end
  always @(negedge ck) begin
    if (nbits < 18) begin
      data[nbits] = dt;
    end
    nbits = nbits + 1;
  end
endmodule : slave_rx_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the synchronous master transmitter
`timescale 1ns/1ps
`default_nettype none
`include "sync_tx_cfg.svh"

module tb_top;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ck_out, ck_oe, dt_out, dt_oe, tick, e;
  logic fl = 1'b0;
  logic clr = 1'b0;
  logic [31:0] rd;
  logic [17:0] rx;
  int nbits, nrise, failures = 0, checks_done = 0;
  realtime per;
  wire ck_w;
  wire dt_w;
  // undriven lines show a changing pattern
  assign ck_w = ck_oe ? ck_out : fl;
  assign dt_w = dt_oe ? dt_out : fl;
  always #50 mclk = ~mclk;
  always @(posedge mclk) fl <= ~fl;

  sync_serial_master_tx i_dut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .transmit_clock_pin_in(ck_w), .transmit_clock_pin_out(ck_out),
    .transmit_clock_pin_oe(ck_oe), .receive_data_pin_in(dt_w),
    .receive_data_pin_out(dt_out), .receive_data_pin_oe(dt_oe), .baud_tick(tick));
  slave_rx_model i_slave (.ck(ck_w), .dt(dt_w), .clr(clr), .data(rx), .nbits(nbits),
    .nrise(nrise), .per(per));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic give_up(input bit hit);
    if (hit) begin
      failures++;
      $display("BAD timeout expected 0 seen 1");
      final_report();
    end
  endtask : give_up

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk("pready", 32'h0, 32'h1);
      final_report();
    end
  endtask : apb

  task automatic pins(input logic ce, input logic de);
    repeat (2) @(posedge mclk);
    #1;
    chk("ck_oe", 32'(ck_oe), 32'(ce));
    chk("dt_oe", 32'(dt_oe), 32'(de));
  endtask : pins

  task automatic send(input logic [7:0] d, input int n);
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    apb(1'b1, `OFS_TX_DATA, 32'(d));
    for (int k = 0; k < 3000 && nbits < n; k++) @(posedge mclk);
    give_up(nbits < n);
    for (int k = 0; k < 20; k++) begin
      apb(1'b0, `OFS_TX_CTRL, 32'h0);
      if (rd[`TSC_SHIFT_EMPTY] === 1'b1) break;
    end
    chk("shift_empty", 32'(rd[`TSC_SHIFT_EMPTY]), 32'h1);
    if (rd[`TSC_SHIFT_EMPTY] !== 1'b1) final_report();
    chk("rises", 32'(nrise), 32'(n));
    chk("bits", 32'(nbits), 32'(n));
  endtask : send

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    apb(1'b0, `OFS_TX_CTRL, 32'h0);
    chk("tsc", rd, 32'h00000002);
    apb(1'b0, `OFS_RX_CTRL, 32'h0);
    chk("rsc", rd, 32'h00000000);
    apb(1'b0, `OFS_TX_DATA, 32'h0);
    chk("tx_data", rd, 32'h00000000);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped", {rd[30:0], e}, 32'h00000001);
    pins(1'b0, 1'b0);
  endtask : t_reset

  task automatic t_pins;
    apb(1'b1, `OFS_RX_CTRL, 32'h80);
    apb(1'b1, `OFS_TX_CTRL, 32'h90);
    pins(1'b1, 1'b0);
    apb(1'b1, `OFS_TX_CTRL, 32'hB0);
    pins(1'b1, 1'b1);
    apb(1'b1, `OFS_RX_CTRL, 32'h90);
    pins(1'b1, 1'b0);
    apb(1'b1, `OFS_RX_CTRL, 32'hA0);
    pins(1'b1, 1'b0);
    apb(1'b1, `OFS_RX_CTRL, 32'h80);
    pins(1'b1, 1'b1);
  endtask : t_pins

  task automatic t_byte;
    apb(1'b1, `OFS_BAUD, 32'h02);
    send(8'hA5, 8);
    chk("byte", 32'(rx[7:0]), 32'hA5);
    chk("period", 32'(int'(per / 100.0)), 32'd12);
  endtask : t_byte

  task automatic t_b2b;
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    apb(1'b1, `OFS_TX_DATA, 32'h3C);
    apb(1'b1, `OFS_TX_DATA, 32'hC3);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("hold_full", 32'(rd[0]), 32'h1);
    for (int k = 0; k < 3000 && nbits < 16; k++) @(posedge mclk);
    give_up(nbits < 16);
    chk("pair", 32'(rx[15:0]), 32'hC33C);
    chk("pair_rises", 32'(nrise), 32'd16);
  endtask : t_b2b

  task automatic t_nine;
    apb(1'b1, `OFS_TX_CTRL, 32'hF1);
    send(8'h55, 9);
    chk("nine", 32'(rx[8:0]), 32'h155);
    apb(1'b1, `OFS_TX_CTRL, 32'hB0);
  endtask : t_nine

  task automatic t_async;
    int n;
    apb(1'b1, `OFS_TX_CTRL, 32'h04);
    apb(1'b1, `OFS_BAUD, 32'h19);
    for (n = 0; n < 1000 && tick !== 1'b1; n++) @(posedge mclk);
    give_up(tick !== 1'b1);
    @(posedge mclk);
    for (n = 0; n < 1000 && tick !== 1'b1; n++) @(posedge mclk);
    give_up(tick !== 1'b1);
    @(posedge mclk);
    for (n = 1; n < 1000 && tick !== 1'b1; n++) @(posedge mclk);
    give_up(tick !== 1'b1);
    chk("tick_gap", 32'(n), 32'd416);
  endtask : t_async

  initial begin
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset();
    t_pins();
    t_byte();
    t_b2b();
    t_nine();
    t_async();
    final_report();
  end
endmodule : tb_top
`default_nettype wire
